// ==== rri_map.vh ====
// Constants for the return and software reset instruction executor.
`ifndef RRI_MAP_VH
`define RRI_MAP_VH
`define RRI_OP_RESET 14'h0001
`define RRI_OP_RETURN 14'h0008
`define RRI_OP_RETFI 14'h0009
`define RRI_OP_RETLIT_MASK 14'h3F00
`define RRI_OP_RETLIT 14'h3400
`define RRI_INT_EN_BIT 7
`define RRI_RSTFLAG_RST 1'h1
`define RRI_INTCTL_RST 8'h00
`define RRI_W_RST 8'h00
`define RRI_PC_RST 15'h0000
`define RRI_STACK_DEPTH 16
`define RRI_RET_CYCLES 2'h2
`endif

// ==== rri_stack.v ====
// Hardware return stack with push and pop, holding return addresses.
`timescale 1ns/100ps
module rri_stack #(
   parameter AW = 15,
   parameter DEPTH = 16,
   parameter PW = 4
) (
   input wire clk,
   input wire resetn,
   input wire push,
   input wire [AW-1:0] push_addr,
   input wire pop,
   output wire [AW-1:0] top_of_stack,
   output wire [PW-1:0] level
);
   reg [AW-1:0] mem_q [0:DEPTH-1];
   reg [PW-1:0] ptr_q;
   wire [PW-1:0] ptr_m1;
   integer i;

   assign ptr_m1 = ptr_q - {{(PW-1){1'b0}}, 1'b1};
   assign top_of_stack = mem_q[ptr_m1];
   assign level = ptr_q;

   // The pointer wraps like a circular stack, so overflow overwrites the oldest entry.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ptr_q <= {PW{1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {AW{1'b0}};
         end
      end else if (push) begin
         mem_q[ptr_q] <= push_addr;
         ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
      end else if (pop) begin
         ptr_q <= ptr_m1;
      end
   end
endmodule

// ==== rri_exec.v ====
// Executor for the three return instructions and the software reset instruction.
// Behaviour
// [RQ1] Software reset triggers a device reset and clears the reset instruction flag.
// [RQ2] Interrupt return pops the stack and loads the top into the program counter.
// [RQ3] Interrupt return sets global interrupt enable, bit 7 of interrupt control.
// [RQ4] Interrupt return completes in two instruction cycles.
// [RQ5] Subroutine return pops stack into program counter, no operands, two cycles.
// [RQ6] Literal return loads its 8-bit immediate into the working register.
// [RQ7] Literal return pops the return address into program counter, two cycles.
// [RQ8] None of these instructions alter carry, digit-carry or zero flags.
`timescale 1ns/100ps
`include "rri_map.vh"
module rri_exec #(
   parameter AW = 15,
   parameter DEPTH = `RRI_STACK_DEPTH,
   parameter PW = 4
) (
   input wire clk,
   input wire resetn,
   input wire instr_valid,
   input wire [13:0] instr,
   input wire call_push,
   input wire [AW-1:0] call_addr,
   input wire int_enable_clear,
   input wire reset_flag_set,
   input wire [2:0] status_in,
   output wire instr_ready,
   output reg [AW-1:0] pc_q,
   output reg pc_load_q,
   output reg [7:0] working_register_q,
   output reg [7:0] interrupt_control_register_q,
   output reg reset_instruction_flag_q,
   output reg device_reset_req_q,
   output wire [2:0] status_out,
   output wire [PW-1:0] stack_level
);
   localparam ST_IDLE = 2'b01;
   localparam ST_FLUSH = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;
   wire [AW-1:0] top_of_stack;
   wire is_reset;
   wire is_ret;
   wire is_retfi;
   wire is_retlit;
   wire take;
   wire pop;

   assign is_reset = (instr == `RRI_OP_RESET);
   assign is_ret = (instr == `RRI_OP_RETURN);
   assign is_retfi = (instr == `RRI_OP_RETFI);
   assign is_retlit = ((instr & `RRI_OP_RETLIT_MASK) == `RRI_OP_RETLIT);
   assign instr_ready = (state_q == ST_IDLE);
   assign take = instr_valid && instr_ready;
   // [RQ2] Stack pop on return.
   // [RQ5] Subroutine return pops.
   // [RQ7] Literal return pops.
   assign pop = take && (is_ret || is_retfi || is_retlit);

   // [RQ8] Flags pass through.
   assign status_out = status_in;

   rri_stack #(
      .AW(AW),
      .DEPTH(DEPTH),
      .PW(PW)
   ) u_stack (
      .clk(clk),
      .resetn(resetn),
      .push(call_push && !pop),
      .push_addr(call_addr),
      .pop(pop),
      .top_of_stack(top_of_stack),
      .level(stack_level)
   );

   // The second cycle of a return is spent flushing the fetched word.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            // [RQ4] Two-cycle returns.
            if (pop) begin
               state_d = ST_FLUSH;
            end
         end
         ST_FLUSH: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         pc_q <= `RRI_PC_RST;
         pc_load_q <= 1'b0;
         working_register_q <= `RRI_W_RST;
         interrupt_control_register_q <= `RRI_INTCTL_RST;
         reset_instruction_flag_q <= `RRI_RSTFLAG_RST;
         device_reset_req_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_load_q <= pop;
         device_reset_req_q <= 1'b0;
         // [RQ2] Load top of stack.
         if (pop) begin
            pc_q <= top_of_stack;
         end
         // [RQ6] Literal to working register.
         if (take && is_retlit) begin
            working_register_q <= instr[7:0];
         end
         // [RQ3] Interrupt return sets enable; it wins over a concurrent clear.
         if (take && is_retfi) begin
            interrupt_control_register_q[`RRI_INT_EN_BIT] <= 1'b1;
         end else if (int_enable_clear) begin
            interrupt_control_register_q[`RRI_INT_EN_BIT] <= 1'b0;
         end
         // [RQ1] Software reset clears the flag and requests a device reset.
         if (take && is_reset) begin
            reset_instruction_flag_q <= 1'b0;
            device_reset_req_q <= 1'b1;
         end else if (reset_flag_set) begin
            reset_instruction_flag_q <= 1'b1;
         end
      end
   end
endmodule

// ==== rri_exec_assertions.sv ====
// Port checks for the return and reset executor.
`timescale 1ns/100ps
module rri_chk #(parameter AW = 15) (
   input wire clk,
   input wire resetn,
   input wire instr_valid,
   input wire [13:0] instr,
   input wire instr_ready,
   input wire [AW-1:0] pc_q,
   input wire pc_load_q,
   input wire [7:0] working_register_q,
   input wire [7:0] interrupt_control_register_q,
   input wire reset_instruction_flag_q,
   input wire device_reset_req_q,
   input wire [2:0] status_in,
   input wire [2:0] status_out
);
   wire t = instr_valid && instr_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_RET: assert property (t && instr == 14'h0008 |=> pc_load_q ##1 instr_ready)
      else $error("subroutine return timing");
   AST_RFI: assert property (t && instr == 14'h0009 |=> !instr_ready ##1 instr_ready)
      else $error("interrupt return timing");
   AST_IEN: assert property (t && instr == 14'h0009 |=> interrupt_control_register_q[7])
      else $error("interrupt enable not set");
   AST_LIT: assert property (
      t && instr[13:8] == 6'h34 |=> pc_load_q
      && working_register_q == $past(instr[7:0]) ##1 instr_ready)
      else $error("lit");
   AST_PC: assert property ($changed(pc_q) |-> pc_load_q)
      else $error("pc");
   AST_RST: assert property (t && instr == 14'h0001 |=> device_reset_req_q)
      else $error("rst");
   AST_FLG: assert property ($fell(reset_instruction_flag_q) |-> device_reset_req_q)
      else $error("flag");
   AST_ONE: assert property (pc_load_q |=> !pc_load_q)
      else $error("load");
   AST_STS: assert property (status_out == status_in)
      else $error("status");
endmodule
bind rri_exec rri_chk #(.AW(AW)) u_chk (.*);

// ==== rri_exec_tb.sv ====
// Self-checking bench for the return and reset executor.
`timescale 1ns/100ps
module rri_exec_tb;
   reg clk = 0, resetn = 0, instr_valid = 0, call_push = 0;
   reg int_enable_clear = 0, reset_flag_set = 0;
   reg [13:0] instr = 14'h0000;
   reg [14:0] call_addr = 15'h0000, st[$];
   reg [2:0] status_in = 3'h0;
   wire instr_ready, pc_load_q, device_reset_req_q, reset_instruction_flag_q;
   wire [14:0] pc_q;
   wire [7:0] working_register_q, interrupt_control_register_q;
   wire [2:0] status_out;
   wire [3:0] stack_level;
   logic [27:0] q[$], got;
   logic [7:0] ew = 8'h00;
   int err_total = 0, samples_checked = 0, i;
   always #2.5 clk = ~clk;
   rri_exec DUT (.*);
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [27:0] g, input [27:0] e);
      begin
         samples_checked++;
         if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task ex(input [13:0] c, input [14:0] p, input g);
      begin
         if (c[13:8] == 6'h34) ew = c[7:0];
         q.push_back({p, ew, g, c != 14'h0001, status_in});
         instr = c;
         instr_valid = 1;
         @(posedge clk) #1;
         instr_valid = 0;
         @(posedge clk) #1;
      end
   endtask
   always @(negedge clk) if (pc_load_q | device_reset_req_q) begin
      got = {pc_q, working_register_q, interrupt_control_register_q[7],
         reset_instruction_flag_q, status_out};
      chk(got, (q.size() > 0) ? q[0] : 28'hFFFFFFF);
      if (q.size() > 0) void'(q.pop_front());
   end
   initial begin
      #2000;
      err_total++;
      complete_run;
   end
   initial begin
      void'($urandom(42));
      repeat (2) @(posedge clk);
      #1 resetn = 1;
      status_in = 3'($urandom);
      for (i = 0; i < 3; i++) begin
         st.push_back(15'($urandom));
         call_addr = st[i];
         call_push = 1;
         @(posedge clk) #1;
      end
      call_push = 0;
      int_enable_clear = 1;
      @(posedge clk) #1;
      int_enable_clear = 0;
      chk(28'(stack_level), 28'h0000003);
      i = $urandom;
      ex(14'h3400 | 14'(i[7:0]), st[2], 0);
      ex(14'h0009, st[1], 1);
      ex(14'h0008, st[0], 1);
      ex(14'h0001, st[0], 1);
      chk(28'(stack_level), 28'h0000000);
      reset_flag_set = 1;
      @(posedge clk) #1;
      reset_flag_set = 0;
      chk(28'(reset_instruction_flag_q), 28'h0000001);
      repeat (2) @(posedge clk);
      if (q.size() != 0) err_total++;
      $display("return sequence done");
      complete_run;
   end
endmodule
